// ### design/tpc_defs.svh
// register map, field positions and limits of the training parameter codec controller
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_PRES 8'h04
`define TPC_OFF_BACKOFF 8'h08
`define TPC_OFF_NRNG 8'h0C
`define TPC_OFF_STATUS 8'h40
`define TPC_OFF_RX_PRES 8'h44
`define TPC_OFF_RX_BACKOFF 8'h48
`define TPC_RNG_BLOCK 3'h1
`define TPC_RX_RNG_BLOCK 3'h3
`define TPC_CTRL_START 0
`define TPC_CTRL_CLR_DONE 1
`define TPC_CTRL_CLR_ERR 2
`define TPC_CTRL_CLR_CFG 3
`define TPC_ST_BUSY 0
`define TPC_ST_DONE 1
`define TPC_ST_ERR 2
`define TPC_ST_CFG 3
`define TPC_ST_NRX_LSB 8
`define TPC_MIN_LSB 0
`define TPC_MAX_LSB 8
`define TPC_STEP_LSB 16
`define TPC_RATE_LO 7'd3
`define TPC_RATE_HI 7'd60
`define TPC_STEP_LO 7'd1
`define TPC_STEP_HI 7'd89
`define TPC_NRNG_MAX 4'd8
`define TPC_NRNG_RST 4'h1
`define TPC_IDX_LAST 5'h1F
`define TPC_POS_LEAD 2'h0
`define TPC_POS_MIN 2'h1
`define TPC_POS_MAX 2'h2
`define TPC_POS_STEP 2'h3
`endif

// ### design/tpc_pkg.sv
// types shared by the training parameter codec controller
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_TX_IDLE = 2'b00,
    TPC_TX_PRES = 2'b01,
    TPC_TX_BO = 2'b10,
    TPC_TX_RNG = 2'b11
  } tpc_tx_e;
  typedef enum logic [1:0] {
    TPC_RX_PRES = 2'b00,
    TPC_RX_BO = 2'b01,
    TPC_RX_RNG = 2'b10,
    TPC_RX_SKIP = 2'b11
  } tpc_rx_e;
  // one rate range as 7-bit values
  typedef struct packed {
    logic [6:0] mn;
    logic [6:0] mx;
    logic [6:0] st;
  } tpc_range_s;
  // one octet on the link with its framing
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tpc_oct_s;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hready;
    logic rd_pend;
    logic wr_pend;
    logic [7:0] addr;
    logic [5:0] pres;
    logic [4:0] bo;
    logic [3:0] nrng;
    tpc_range_s [7:0] rng;
    tpc_tx_e tx_state;
    logic [4:0] tx_idx;
    tpc_oct_s tx;
    logic cfg_err;
    tpc_rx_e rx_state;
    logic [4:0] rx_idx;
    logic [5:0] rx_pres;
    logic [4:0] rx_bo;
    tpc_range_s [7:0] rx_rng;
    logic [3:0] rx_n;
    logic rx_done;
    logic rx_err;
  } tpc_state_s;
endpackage

// ### design/tpc_host.sv
// controller that frames and parses training parameter octets toward the peer transceiver
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "tpc_defs.svh"
module tpc_host
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // octets toward the peer
  output tpc_oct_s tx_oct,
  input wire logic tx_ready,
  // octets from the peer
  input tpc_oct_s rx_oct
);

  tpc_state_s s_q;
  tpc_state_s s_d;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // a value only scales the payload rate, so range checks are all we need
  function automatic logic tpc_rng_ok(input tpc_range_s r);
    tpc_rng_ok = (r.mn >= `TPC_RATE_LO) && (r.mn <= `TPC_RATE_HI) &&
                 (r.mx >= `TPC_RATE_LO) && (r.mx <= `TPC_RATE_HI) &&
                 (r.st >= `TPC_STEP_LO) && (r.st <= `TPC_STEP_HI);
  endfunction

  // octet at position pos of one range group
  function automatic logic [7:0] tpc_enc(input tpc_range_s r, input logic [1:0] pos);
    case (pos)
      // top bits, reserved bits 8..4 left zero
      `TPC_POS_LEAD: tpc_enc = {5'h00, r.st[6], r.mx[6], r.mn[6]};
      `TPC_POS_MIN: tpc_enc = {2'h0, r.mn[5:0]};
      `TPC_POS_MAX: tpc_enc = {2'h0, r.mx[5:0]};
      default: tpc_enc = {2'h0, r.st[5:0]};
    endcase
  endfunction

  function automatic logic [31:0] tpc_rword(input tpc_range_s r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`TPC_MIN_LSB +: 7] = r.mn;
    w[`TPC_MAX_LSB +: 7] = r.mx;
    w[`TPC_STEP_LSB +: 7] = r.st;
    tpc_rword = w;
  endfunction

  function automatic logic [31:0] tpc_read(input tpc_state_s s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a[7:5] == `TPC_RNG_BLOCK) begin
      w = tpc_rword(s.rng[a[4:2]]);
    end else if (a[7:5] == `TPC_RX_RNG_BLOCK) begin
      w = tpc_rword(s.rx_rng[a[4:2]]);
    end else begin
      case (a)
        `TPC_OFF_PRES: w[5:0] = s.pres;
        `TPC_OFF_BACKOFF: w[4:0] = s.bo;
        `TPC_OFF_NRNG: w[3:0] = s.nrng;
        `TPC_OFF_STATUS: begin
          w[`TPC_ST_BUSY] = (s.tx_state != TPC_TX_IDLE);
          w[`TPC_ST_DONE] = s.rx_done;
          w[`TPC_ST_ERR] = s.rx_err;
          w[`TPC_ST_CFG] = s.cfg_err;
          w[`TPC_ST_NRX_LSB +: 4] = s.rx_n;
        end
        `TPC_OFF_RX_PRES: w[5:0] = s.rx_pres;
        `TPC_OFF_RX_BACKOFF: w[4:0] = s.rx_bo;
        default: w = 32'h0000_0000;
      endcase
    end
    tpc_read = w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic cfg_ok;
    logic start;
    logic tx_adv;
    logic [2:0] grp;
    logic [1:0] pos;
    tpc_range_s cur;
    cfg_ok = 1'b0;
    start = 1'b0;
    tx_adv = 1'b0;
    grp = 3'h0;
    pos = 2'h0;
    cur = '0;
    s_d = s_q;

    // one to eight ranges; every range in use must be legal
    cfg_ok = (s_q.nrng != 4'h0) && (s_q.nrng <= `TPC_NRNG_MAX);
    for (int i = 0; i < 8; i++) begin
      if ((4'(i) < s_q.nrng) && !tpc_rng_ok(s_q.rng[i])) begin
        cfg_ok = 1'b0;
      end
    end

    // bus data phase: writes commit here, reads answer one cycle later
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      if (s_q.addr[7:5] == `TPC_RNG_BLOCK) begin
        s_d.rng[s_q.addr[4:2]].mn = hwdata[`TPC_MIN_LSB +: 7];
        s_d.rng[s_q.addr[4:2]].mx = hwdata[`TPC_MAX_LSB +: 7];
        s_d.rng[s_q.addr[4:2]].st = hwdata[`TPC_STEP_LSB +: 7];
      end else begin
        case (s_q.addr)
          `TPC_OFF_CTRL: begin
            start = hwdata[`TPC_CTRL_START];
            if (hwdata[`TPC_CTRL_CLR_DONE]) begin
              s_d.rx_done = 1'b0;
            end
            if (hwdata[`TPC_CTRL_CLR_ERR]) begin
              s_d.rx_err = 1'b0;
            end
            if (hwdata[`TPC_CTRL_CLR_CFG]) begin
              s_d.cfg_err = 1'b0;
            end
          end
          `TPC_OFF_PRES: s_d.pres = hwdata[5:0];
          `TPC_OFF_BACKOFF: s_d.bo = hwdata[4:0];
          `TPC_OFF_NRNG: s_d.nrng = hwdata[3:0];
          default: s_d.wr_pend = 1'b0;
        endcase
      end
    end
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.hready = 1'b1;
      s_d.hrdata = tpc_read(s_q, s_q.addr);
    end
    if (hsel && htrans[1] && hready) begin
      s_d.addr = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_pend = !hwrite;
      s_d.hready = hwrite;
    end

    // transmit framer; an octet is retired when the peer takes it
    tx_adv = s_q.tx.valid && tx_ready;
    grp = s_q.tx_idx[4:2];
    pos = s_q.tx_idx[1:0];
    if (tx_adv) begin
      s_d.tx.valid = 1'b0;
      s_d.tx.last = 1'b0;
    end
    case (s_q.tx_state)
      TPC_TX_IDLE: begin
        if (start && cfg_ok) begin
          // presence flags in bits 1..6, bits 7-8 zero
          s_d.tx.data = {2'h0, s_q.pres};
          s_d.tx.valid = 1'b1;
          // empty presence octet ends the frame
          s_d.tx.last = (s_q.pres == 6'h00);
          s_d.tx_state = TPC_TX_PRES;
        end else if (start) begin
          s_d.cfg_err = 1'b1;
        end
      end
      TPC_TX_PRES: begin
        if (tx_adv) begin
          if (s_q.pres == 6'h00) begin
            s_d.tx_state = TPC_TX_IDLE;
          end else begin
            // backoff count with bit 6 held zero
            s_d.tx.data = {3'h0, s_q.bo};
            s_d.tx.valid = 1'b1;
            s_d.tx_state = TPC_TX_BO;
          end
        end
      end
      TPC_TX_BO: begin
        if (tx_adv) begin
          s_d.tx.data = tpc_enc(s_q.rng[0], `TPC_POS_LEAD);
          s_d.tx.valid = 1'b1;
          s_d.tx_idx = 5'h00;
          s_d.tx_state = TPC_TX_RNG;
        end
      end
      TPC_TX_RNG: begin
        if (tx_adv) begin
          // stop after the last octet of range nrng
          if ((pos == `TPC_POS_STEP) && ({1'b0, grp} + 4'h1 == s_q.nrng)) begin
            s_d.tx_state = TPC_TX_IDLE;
          end else begin
            s_d.tx_idx = s_q.tx_idx + 5'h01;
            s_d.tx.data = tpc_enc(s_q.rng[s_d.tx_idx[4:2]], s_d.tx_idx[1:0]);
            s_d.tx.valid = 1'b1;
            s_d.tx.last = (s_d.tx_idx[1:0] == `TPC_POS_STEP) &&
                          ({1'b0, s_d.tx_idx[4:2]} + 4'h1 == s_q.nrng);
          end
        end
      end
      default: s_d.tx_state = TPC_TX_IDLE;
    endcase

    // receive parser; error and done flags are set after the clears so a set wins
    grp = s_q.rx_idx[4:2];
    pos = s_q.rx_idx[1:0];
    if (rx_oct.valid) begin
      case (s_q.rx_state)
        TPC_RX_PRES: begin
          s_d.rx_pres = rx_oct.data[5:0];
          s_d.rx_idx = 5'h00;
          if (rx_oct.data[5:0] == 6'h00) begin
            // nothing may follow an empty presence octet
            s_d.rx_state = rx_oct.last ? TPC_RX_PRES : TPC_RX_SKIP;
            s_d.rx_err = s_d.rx_err || !rx_oct.last;
            s_d.rx_done = rx_oct.last || s_d.rx_done;
            s_d.rx_n = 4'h0;
          end else if (rx_oct.last) begin
            s_d.rx_err = 1'b1;
            s_d.rx_done = 1'b1;
          end else begin
            s_d.rx_state = TPC_RX_BO;
          end
        end
        TPC_RX_BO: begin
          s_d.rx_bo = rx_oct.data[4:0];
          // reserved bit 6 set, or frame cut short
          if (rx_oct.data[5] || rx_oct.last) begin
            s_d.rx_err = 1'b1;
          end
          s_d.rx_state = rx_oct.last ? TPC_RX_PRES : TPC_RX_RNG;
          s_d.rx_done = rx_oct.last || s_d.rx_done;
        end
        TPC_RX_RNG: begin
          cur = s_q.rx_rng[grp];
          case (pos)
            `TPC_POS_LEAD: begin
              // top bits; reserved bits 6..4 must be zero
              cur.mn[6] = rx_oct.data[0];
              cur.mx[6] = rx_oct.data[1];
              cur.st[6] = rx_oct.data[2];
              if (rx_oct.data[5:3] != 3'h0) begin
                s_d.rx_err = 1'b1;
              end
            end
            // low six bits joined to the top bit
            `TPC_POS_MIN: cur.mn[5:0] = rx_oct.data[5:0];
            `TPC_POS_MAX: cur.mx[5:0] = rx_oct.data[5:0];
            default: begin
              cur.st[5:0] = rx_oct.data[5:0];
              // completed range out of its window
              if (!tpc_rng_ok(cur)) begin
                s_d.rx_err = 1'b1;
              end
            end
          endcase
          s_d.rx_rng[grp] = cur;
          s_d.rx_idx = s_q.rx_idx + 5'h01;
          if (rx_oct.last) begin
            // frame must end on a whole group
            if (pos != `TPC_POS_STEP) begin
              s_d.rx_err = 1'b1;
            end
            s_d.rx_n = {1'b0, grp} + 4'h1;
            s_d.rx_done = 1'b1;
            s_d.rx_state = TPC_RX_PRES;
          end else if (s_q.rx_idx == `TPC_IDX_LAST) begin
            s_d.rx_err = 1'b1;
            s_d.rx_state = TPC_RX_SKIP;
          end
        end
        default: begin
          if (rx_oct.last) begin
            s_d.rx_done = 1'b1;
            s_d.rx_state = TPC_RX_PRES;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.hready <= 1'b1;
      s_q.nrng <= `TPC_NRNG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hready;
  // responses are always okay; unmapped reads give zero
  assign hresp = 1'b0;
  assign tx_oct = s_q.tx;

endmodule

// ### bench/tpc_host_monitor.sv
// port assertions for the training parameter codec controller
`timescale 1ns/1ps
module tpc_host_monitor
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // link
  input tpc_oct_s tx_oct,
  input wire logic tx_ready,
  input tpc_oct_s rx_oct
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [5:0] idx_q;
  logic take;
  logic req;
  assign take = tx_oct.valid && tx_ready;
  assign req = hsel && htrans[1] && hready;
  // position of the offered octet within its frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q <= 6'h00;
    end else if (take) begin
      idx_q <= tx_oct.last ? 6'h00 : idx_q + 6'h01;
    end
  end
  sequence rd_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (req && !hwrite |=> rd_wait_s) else $error("read wait state wrong");
  wr_nowait_a: assert property (req && hwrite |=> hreadyout) else $error("write was stalled");
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  zero_pres_a: assert property (tx_oct.valid && idx_q == 6'd0 |-> tx_oct.last == (tx_oct.data[5:0] == 6'h00))
    else $error("presence octet framing wrong");
  bo_rsvd_a: assert property (tx_oct.valid && idx_q == 6'd1 |-> tx_oct.data[7:5] == 3'h0 && !tx_oct.last)
    else $error("backoff octet wrong");
  lead_rsvd_a: assert property (tx_oct.valid && idx_q >= 6'd2 && idx_q[1:0] == 2'b10 |-> tx_oct.data[7:3] == 5'h00)
    else $error("lead reserved bit set");
  rate_top_a: assert property (tx_oct.valid && idx_q >= 6'd2 && idx_q[1:0] == 2'b10 |-> tx_oct.data[1:0] == 2'b00)
    else $error("min or max top bit set");
  last_pos_a: assert property (tx_oct.valid && tx_oct.last && idx_q != 6'd0 |->
    idx_q[1:0] == 2'b01 && idx_q >= 6'd5 && idx_q <= 6'd33)
    else $error("frame ends off a group");
endmodule
bind tpc_host tpc_host_monitor tpc_host_monitor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .tx_oct(tx_oct), .tx_ready(tx_ready), .rx_oct(rx_oct));

// ### bench/tpc_peer.sv
// peer transceiver model: takes octets, may stall, replays frames
`timescale 1ns/1ps
module tpc_peer
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // octets from the controller
  input tpc_oct_s tx_oct,
  output logic tx_ready,
  // octets toward the controller
  output tpc_oct_s rx_oct,
  // slow mode
  input wire logic stall
);
  logic [8:0] got[$];
  initial begin
    tx_ready = 1'b1;
    rx_oct = '0;
  end
  // slow mode takes every other cycle
  always @(posedge hclk) begin
    if (hresetn && tx_oct.valid && tx_ready) got.push_back({tx_oct.last, tx_oct.data});
    tx_ready <= stall ? !tx_ready : 1'b1;
  end
  task automatic send(input logic [8:0] f[$]);
    foreach (f[k]) begin
      @(posedge hclk);
      rx_oct <= {1'b1, f[k]};
    end
    @(posedge hclk);
    // released line shows the inverse, not a stale octet
    rx_oct <= {2'b00, ~f[f.size() - 1][7:0]};
  endtask
endmodule

// ### bench/tpc_host_tb.sv
// self-checking bench of the training parameter codec controller
`timescale 1ns/1ps
module tpc_host_tb
  import tpc_pkg::*;
;
  typedef struct packed {
    logic [5:0] pres;
    logic [4:0] bo;
    logic [3:0] n;
    logic [6:0] mn;
    logic [6:0] mx;
    logic [6:0] st;
    logic bad;
    logic slow;
  } tpc_row_s;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_ready, stall;
  logic [31:0] haddr, hwdata, hrdata, d, s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  tpc_oct_s tx_oct, rx_oct;
  logic [8:0] exp[$], base[$];
  int fail_count, checks, k;
  tpc_row_s r;
  tpc_row_s rows [14] = '{
    '{6'h01, 5'h00, 4'h1, 7'd3, 7'd60, 7'd1, 1'b0, 1'b0}, '{6'h02, 5'h1F, 4'h2, 7'd60, 7'd60, 7'd89, 1'b0, 1'b1},
    '{6'h04, 5'h0A, 4'h8, 7'd3, 7'd3, 7'd64, 1'b0, 1'b0}, '{6'h08, 5'h01, 4'h3, 7'd4, 7'd59, 7'd2, 1'b0, 1'b1},
    '{6'h10, 5'h10, 4'h1, 7'd33, 7'd34, 7'd63, 1'b0, 1'b0}, '{6'h20, 5'h02, 4'h2, 7'd10, 7'd20, 7'd88, 1'b0, 1'b0},
    '{6'h3F, 5'h15, 4'h7, 7'd3, 7'd60, 7'd1, 1'b0, 1'b0}, '{6'h00, 5'h05, 4'h1, 7'd3, 7'd3, 7'd1, 1'b0, 1'b0},
    '{6'h01, 5'h00, 4'h0, 7'd3, 7'd3, 7'd1, 1'b1, 1'b0}, '{6'h01, 5'h00, 4'h9, 7'd3, 7'd3, 7'd1, 1'b1, 1'b0},
    '{6'h01, 5'h00, 4'h1, 7'd2, 7'd3, 7'd1, 1'b1, 1'b0}, '{6'h01, 5'h00, 4'h1, 7'd3, 7'd61, 7'd1, 1'b1, 1'b0},
    '{6'h01, 5'h00, 4'h1, 7'd3, 7'd3, 7'd0, 1'b1, 1'b0}, '{6'h01, 5'h00, 4'h1, 7'd3, 7'd3, 7'd90, 1'b1, 1'b0}};
  tpc_host tpc_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_oct(tx_oct), .tx_ready(tx_ready), .rx_oct(rx_oct));
  tpc_peer tpc_peer_i (.hclk(hclk), .hresetn(hresetn), .tx_oct(tx_oct), .tx_ready(tx_ready), .rx_oct(rx_oct),
    .stall(stall));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_o(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_w(nm, 32'(e), 32'(g));
  endtask
  // sample at the falling edge what the next rising edge will see
  task automatic wait_rdy(output logic [31:0] rd);
    logic rdy;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy(rd);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fail_count++;
    conclude();
  end
  initial begin
    {hsel, hwrite, stall, hresetn} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      stall <= r.slow;
      tpc_peer_i.got.delete();
      bus(1'b1, 8'h04, 32'(r.pres), d);
      bus(1'b1, 8'h08, 32'(r.bo), d);
      bus(1'b1, 8'h0C, 32'(r.n), d);
      for (k = 0; k < 8; k++) bus(1'b1, {3'h1, k[2:0], 2'h0}, {9'h0, r.st, 1'b0, r.mx, 1'b0, r.mn}, d);
      bus(1'b1, 8'h00, 32'h1, d);
      k = 0;
      do begin
        bus(1'b0, 8'h40, 32'h0, s);
        k++;
      end while (s[0] !== 1'b0 && k < 100);
      cmp_w("tx busy", 32'h0, 32'(s[0]));
      exp.delete();
      if (!r.bad) exp.push_back({r.pres == 6'h00, 2'h0, r.pres});
      if (!r.bad && r.pres != 6'h00) begin
        exp.push_back({4'h0, r.bo});
        for (k = 0; k < r.n; k++) begin
          exp.push_back({6'h00, r.st[6], r.mx[6], r.mn[6]});
          exp.push_back({3'h0, r.mn[5:0]});
          exp.push_back({3'h0, r.mx[5:0]});
          exp.push_back({k == r.n - 1, 2'h0, r.st[5:0]});
        end
      end
      cmp_w("octet count", 32'(exp.size()), 32'(tpc_peer_i.got.size()));
      foreach (exp[j]) cmp_o("octet", exp[j], tpc_peer_i.got[j]);
      cmp_w("cfg error", 32'(r.bad), 32'(s[3]));
      bus(1'b1, 8'h00, 32'h8, d);
      if (!r.bad) begin
        tpc_peer_i.send(tpc_peer_i.got);
        bus(1'b0, 8'h40, 32'h0, s);
        cmp_w("rx status", 32'({(r.pres != 6'h00) ? r.n : 4'h0, 2'b01}), 32'({s[11:8], s[2:1]}));
        bus(1'b0, 8'h44, 32'h0, d);
        cmp_w("rx pres", 32'(r.pres), d);
        if (r.pres != 6'h00) begin
          bus(1'b0, 8'h48, 32'h0, d);
          cmp_w("rx backoff", 32'(r.bo), d);
          bus(1'b0, {3'h3, r.n[2:0] - 3'h1, 2'h0}, 32'h0, d);
          cmp_w("rx range", {9'h0, r.st, 1'b0, r.mx, 1'b0, r.mn}, d);
        end
        bus(1'b1, 8'h00, 32'h6, d);
      end
      $display("row %0d done", i);
    end
    for (int e = 0; e < 5; e++) begin
      base = '{9'h001, 9'h000, 9'h000, 9'h003, 9'h003, 9'h101};
      if (e == 0) base[1] = 9'h020;
      if (e == 1) base[2] = 9'h008;
      if (e == 2) base[3] = 9'h002;
      if (e == 3) base = '{9'h001, 9'h000, 9'h000, 9'h103};
      // octets after an empty presence octet
      if (e == 4) base = '{9'h000, 9'h100};
      tpc_peer_i.send(base);
      bus(1'b0, 8'h40, 32'h0, s);
      cmp_w("rx error", 32'h1, 32'(s[2]));
      bus(1'b1, 8'h00, 32'h6, d);
      bus(1'b0, 8'h40, 32'h0, s);
      cmp_w("error cleared", 32'h0, 32'(s[2]));
    end
    $display("rx error test done");
    // leave non-reset values behind so the reset checks can trip
    bus(1'b1, 8'h08, 32'h15, d);
    bus(1'b1, 8'h0C, 32'h9, d);
    bus(1'b1, 8'h00, 32'h1, d);
    bus(1'b0, 8'h40, 32'h0, s);
    cmp_w("cfg error", 32'h1, 32'(s[3]));
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 8'h10, 32'hFFFF, d);
    for (k = 0; k < 5; k++) begin
      bus(1'b0, 8'(k == 4 ? 8'h40 : 4 * k + 4), 32'h0, d);
      cmp_w("reset value", 32'(k == 2), d);
    end
    $display("reset test done");
    conclude();
  end
endmodule
